// [bench/pirq_periph_model.sv]
// behavioural peripherals: event strobes and serial buffer levels
`timescale 1ns/1ps
module pirq_periph_model
    import pirq_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [REG_W-1:0] fire,
    input  wire logic             rx_lv,
    input  wire logic             tx_lv,
    output logic      [REG_W-1:0] periph_events,
    output logic                  serial_rx_buffer_full,
    output logic                  serial_tx_buffer_empty
);
    // strobes last one cycle; buffer bits stay as levels
    always_ff @(posedge clock or negedge resetn)
        if (!resetn) {periph_events, serial_rx_buffer_full, serial_tx_buffer_empty} <= '0;
        else {periph_events, serial_rx_buffer_full, serial_tx_buffer_empty} <= {fire, rx_lv, tx_lv};
endmodule

// [bench/pirq_regs_chk.sv]
// port assertions for the peripheral interrupt register block
`timescale 1ns/1ps
module pirq_regs_chk
    import pirq_pkg::*;
(
    input wire logic              clock,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0]   avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic [REG_W-1:0]  periph_events,
    input wire logic              serial_rx_buffer_full,
    input wire logic              serial_tx_buffer_empty,
    input wire logic              periph_irq_req,
    input wire logic              irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
    property p_answer; s_req |=> s_ans; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");
    property p_idle; !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("stray bus answer");
    property p_hold; !$fell(avs_waitrequest) |-> $stable(avs_readdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_upper; avs_readdata[DATA_W-1:REG_W] == '0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    // cause sits two samples back: write commit or event edge, flag/enable update, then request flop
    property p_req_up; $rose(periph_irq_req) |->
        $past(avs_write || serial_rx_buffer_full || serial_tx_buffer_empty || (|periph_events), 2); endproperty
    a_req_up: assert property (p_req_up) else $error("request without cause");
    // only a committed write or a falling buffer level may drop the request
    property p_req_dn; $fell(periph_irq_req) |-> $past(avs_write, 2) ||
        ($past(serial_rx_buffer_full, 3) && $past(!serial_rx_buffer_full, 2)) ||
        ($past(serial_tx_buffer_empty, 3) && $past(!serial_tx_buffer_empty, 2)); endproperty
    a_req_dn: assert property (p_req_dn) else $error("request dropped alone");
    // mask write reaches irq one stage sooner than a flag rise, which passes the status bit first
    property p_irq_up; $rose(irq) |-> $past(avs_write, 2) || $past(avs_write, 3) ||
        $past(serial_rx_buffer_full || serial_tx_buffer_empty || (|periph_events), 3); endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq without cause");
    property p_irq_dn; $fell(irq) |-> $past(avs_write, 2); endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("irq dropped alone");
endmodule
bind pirq_regs pirq_regs_chk u_chk (.clock, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .periph_events, .serial_rx_buffer_full,
    .serial_tx_buffer_empty, .periph_irq_req, .irq);

// [bench/pirq_regs_tb.sv]
// self-checking bench for the peripheral interrupt registers
`timescale 1ns/1ps
module pirq_regs_tb import pirq_pkg::*;;
    logic        clock = 0, resetn = 0, rd = 0, wr = 0, rx = 0, tx = 0, wq, req, irq, rxf, txe;
    logic [7:0]  addr = 0, fire = 0, ev;
    logic [3:0]  be = 4'h1;
    logic [31:0] wdata = 0, rdata, q, v;
    int          seed = 32'h6023B6A3, compares = 0, miscompares = 0;
    logic [7:0]  ofs [6] = '{FLAGS_OFS, ENABLES_OFS, CORE_CTRL_OFS, EVT_STATUS_OFS, EVT_MASK_OFS, 8'h40};
    logic [7:0]  cv [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
    always #10 clock = ~clock;
    pirq_regs DUT (.clock, .resetn, .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wq), .periph_events(ev),
        .serial_rx_buffer_full(rxf), .serial_tx_buffer_empty(txe), .periph_irq_req(req), .irq);
    pirq_periph_model PM (.clock, .resetn, .fire, .rx_lv(rx), .tx_lv(tx), .periph_events(ev),
        .serial_rx_buffer_full(rxf), .serial_tx_buffer_empty(txe));
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        {addr, wdata, wr, rd} <= {a, d, w, !w};
        do begin
            @(posedge clock);
            n++;
        end while (wq !== 1'b0 && n < 50);
        if (wq !== 1'b0) begin
            miscompares++;
            stop_test();
        end
        q = rdata;
        {rd, wr} <= 2'h0;
        @(posedge clock);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(0, a, 0);
        check(n, e, q);
    endtask
    // bits 5 and 4 come from buffer levels, the rest from strobes
    task automatic pulse(input int b);
        if (b == 5) rx <= 1;
        else if (b == 4) tx <= 1;
        else fire <= 8'h01 << b;
        @(posedge clock);
        fire <= 0;
        repeat (3) @(posedge clock);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1;
        @(posedge clock);
        foreach (ofs[i]) rdc("reset value", ofs[i], 0);
        repeat (4) begin
            v = $random(seed);
            bus(1, ENABLES_OFS, v);
            bus(1, 8'h40, v);
            rdc("enables", ENABLES_OFS, {24'h0, v[7:0]});
        end
        rdc("unmapped", 8'h40, 0);
        // lane 0 off: the write must leave the register untouched
        be <= 4'hE;
        bus(1, ENABLES_OFS, ~v);
        be <= 4'h1;
        rdc("lane off", ENABLES_OFS, {24'h0, v[7:0]});
        bus(1, CORE_CTRL_OFS, 32'hFF);
        rdc("core ctrl", CORE_CTRL_OFS, 32'hC0);
        $display("test registers done");
        for (int b = 0; b < 8; b++) begin
            v = $random(seed) & ~(32'h1 << b);
            bus(1, FLAGS_OFS, 0);
            bus(1, ENABLES_OFS, v);
            pulse(b);
            rdc("flag set", FLAGS_OFS, 32'h1 << b);
            check("blocked", 0, req);
            bus(1, ENABLES_OFS, v | (32'h1 << b));
            @(posedge clock);
            check("allowed", 1, req);
            bus(1, FLAGS_OFS, 0);
            rdc("after clear", FLAGS_OFS, (b == 4 || b == 5) ? 32'h1 << b : 0);
            {rx, tx} <= 2'h0;
        end
        // small package software: reserved enable kept clear, its event raises nothing
        v = $random(seed) & 32'h7F;
        bus(1, ENABLES_OFS, v);
        pulse(7);
        check("reserved kept clear", 0, req);
        bus(1, FLAGS_OFS, 0);
        bus(1, ENABLES_OFS, 1);
        pulse(0);
        foreach (cv[i]) begin
            bus(1, CORE_CTRL_OFS, cv[i]);
            @(posedge clock);
            check("core gate", cv[i] == 8'hC0, req);
        end
        bus(1, CORE_CTRL_OFS, 0);
        pulse(3);
        rdc("flag without global", FLAGS_OFS, 32'h09);
        // strobe lands on the very edge that commits the clearing write
        fork
            bus(1, FLAGS_OFS, 0);
            begin
                fire <= 8'h02;
                @(posedge clock);
                fire <= 0;
            end
        join
        rdc("event beats clear", FLAGS_OFS, 32'h02);
        $display("test gating done");
        bus(1, EVT_STATUS_OFS, 32'hFF);
        bus(1, EVT_MASK_OFS, 1);
        pulse(0);
        @(posedge clock);
        check("irq raised", 1, irq);
        rdc("status set", EVT_STATUS_OFS, 1);
        bus(1, EVT_MASK_OFS, 0);
        @(posedge clock);
        check("irq masked", 0, irq);
        bus(1, EVT_MASK_OFS, 1);
        bus(1, EVT_STATUS_OFS, 1);
        @(posedge clock);
        check("irq cleared", 0, irq);
        rdc("status clear", EVT_STATUS_OFS, 0);
        $display("test interrupt done");
        stop_test();
    end
endmodule

// [logic/pirq_flag_bank.sv]
// peripheral flag register: sticky event bits and two live buffer bits
`timescale 1ns/1ps
module pirq_flag_bank
    import pirq_pkg::*;
(
    input wire logic    clock,
    input wire logic    resetn,
    pirq_flag_if.bank   fl
);
    logic [REG_W-1:0] flags_reg;
    logic [REG_W-1:0] flags_next;

    genvar i;
    generate
        for (i = 0; i < REG_W; i++) begin : g_flag
            if (i == BIT_SERIAL_RX) begin : g_rx
                // tracks buffer state, software writes ignored
                assign flags_next[i] = fl.rx_full;
            end else if (i == BIT_SERIAL_TX) begin : g_tx
                assign flags_next[i] = fl.tx_empty;
            end else begin : g_sticky
                // event ORed after the write so a set beats a clear
                assign flags_next[i] = fl.events[i] | (fl.wr_en ? fl.wr_data[i] : flags_reg[i]);
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign fl.flags = flags_reg;
endmodule

// [logic/pirq_flag_if.sv]
// link between the bus-side control and the flag register bank
`timescale 1ns/1ps
interface pirq_flag_if #(parameter int W = 8);
    logic [W-1:0] events;
    logic         wr_en;
    logic [W-1:0] wr_data;
    logic         rx_full;
    logic         tx_empty;
    logic [W-1:0] flags;

    modport bank (input events, input wr_en, input wr_data, input rx_full, input tx_empty, output flags);
    modport ctrl (output events, output wr_en, output wr_data, output rx_full, output tx_empty, input flags);
endinterface

// [logic/pirq_pkg.sv]
// constants, offsets and types of the peripheral interrupt enable/flag registers
package pirq_pkg;
    localparam int REG_W  = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;

    localparam logic [ADDR_W-1:0] FLAGS_OFS      = 8'h0C;
    localparam logic [ADDR_W-1:0] ENABLES_OFS    = 8'h8C;
    localparam logic [ADDR_W-1:0] CORE_CTRL_OFS  = 8'h10;
    localparam logic [ADDR_W-1:0] EVT_STATUS_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] EVT_MASK_OFS   = 8'h18;

    localparam int BIT_PAR_SLAVE_PORT = 7;
    localparam int BIT_CONVERTER      = 6;
    localparam int BIT_SERIAL_RX      = 5;
    localparam int BIT_SERIAL_TX      = 4;
    localparam int BIT_SYNC_SERIAL    = 3;
    localparam int BIT_CAPCOMP        = 2;
    localparam int BIT_TIMER_B_MATCH  = 1;
    localparam int BIT_TIMER_A_OVF    = 0;

    localparam int BIT_GLOBAL_IRQ_ENABLE        = 7;
    localparam int BIT_PERIPHERAL_MASTER_ENABLE = 6;

    localparam logic [REG_W-1:0] FLAGS_RESET      = 8'h00;
    localparam logic [REG_W-1:0] ENABLES_RESET    = 8'h00;
    localparam logic [REG_W-1:0] CORE_CTRL_RESET  = 8'h00;
    localparam logic [REG_W-1:0] EVT_STATUS_RESET = 8'h00;
    localparam logic [REG_W-1:0] EVT_MASK_RESET   = 8'h00;
    localparam logic [REG_W-1:0] CORE_CTRL_MASK   = 8'hC0;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } pirq_bus_state_t;
endpackage

// [logic/pirq_regs.sv]
// peripheral interrupt enable and flag registers with Avalon-MM slave
`timescale 1ns/1ps
module pirq_regs
    import pirq_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [BE_W-1:0]   avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [REG_W-1:0]  periph_events,
    input  wire logic              serial_rx_buffer_full,
    input  wire logic              serial_tx_buffer_empty,
    output logic                   periph_irq_req,
    output logic                   irq
);
    pirq_bus_state_t  bus_state_reg;
    pirq_bus_state_t  bus_state_next;
    logic             waitrequest_reg;
    logic             waitrequest_next;
    logic [DATA_W-1:0] readdata_reg;
    logic [DATA_W-1:0] readdata_next;
    logic [REG_W-1:0] enables_reg;
    logic [REG_W-1:0] enables_next;
    logic [REG_W-1:0] core_ctrl_reg;
    logic [REG_W-1:0] core_ctrl_next;
    logic [REG_W-1:0] evt_status_reg;
    logic [REG_W-1:0] evt_status_next;
    logic [REG_W-1:0] evt_mask_reg;
    logic [REG_W-1:0] evt_mask_next;
    logic [REG_W-1:0] pend_prev_reg;
    logic             req_reg;
    logic             req_next;
    logic             irq_reg;
    logic             irq_next;

    wire              bus_req;
    wire              wr_fire;
    wire              lane0;
    wire              hit_flags;
    wire              hit_enables;
    wire              hit_core;
    wire              hit_status;
    wire              hit_mask;
    wire [REG_W-1:0]  wdata8;
    wire [REG_W-1:0]  rd_value8;
    wire [REG_W-1:0]  pend;
    wire [REG_W-1:0]  pend_rise;
    wire [REG_W-1:0]  status_clear;
    wire              master_ok;

    pirq_flag_if #(.W(REG_W)) fl ();

    pirq_flag_bank u_flags (
        .clock  (clock),
        .resetn (resetn),
        .fl     (fl.bank)
    );

    // bus decode; request sampled once idle, committed in the answer cycle
    assign bus_req     = avs_read | avs_write;
    assign wr_fire     = avs_write & (bus_state_reg == BUS_ANSWER);
    assign lane0       = avs_byteenable[0];
    assign wdata8      = avs_writedata[REG_W-1:0];
    assign hit_flags   = (avs_address == FLAGS_OFS);
    assign hit_enables = (avs_address == ENABLES_OFS);
    assign hit_core    = (avs_address == CORE_CTRL_OFS);
    assign hit_status  = (avs_address == EVT_STATUS_OFS);
    assign hit_mask    = (avs_address == EVT_MASK_OFS);

    // unmapped addresses read zero
    assign rd_value8 = hit_flags   ? fl.flags       :
                       hit_enables ? enables_reg    :
                       hit_core    ? core_ctrl_reg  :
                       hit_status  ? evt_status_reg :
                       hit_mask    ? evt_mask_reg   : 8'h00;

    // flag bank inputs
    assign fl.events   = periph_events;
    assign fl.wr_en    = wr_fire & hit_flags & lane0;
    assign fl.wr_data  = wdata8;
    assign fl.rx_full  = serial_rx_buffer_full;
    assign fl.tx_empty = serial_tx_buffer_empty;

    // per-source gating by its enable bit
    assign pend      = fl.flags & enables_reg;
    assign master_ok = core_ctrl_reg[BIT_PERIPHERAL_MASTER_ENABLE] & core_ctrl_reg[BIT_GLOBAL_IRQ_ENABLE];
    assign req_next  = (|pend) & master_ok;

    // enabling an already set flag raises at once; software avoids that
    assign pend_rise    = pend & ~pend_prev_reg;
    assign status_clear = (wr_fire & hit_status & lane0) ? wdata8 : 8'h00;

    always_comb begin
        bus_state_next   = bus_state_reg;
        waitrequest_next = 1'b1;
        readdata_next    = readdata_reg;
        unique case (bus_state_reg)
            BUS_IDLE: begin
                if (bus_req) begin
                    bus_state_next   = BUS_ANSWER;
                    waitrequest_next = 1'b0;
                    readdata_next    = {{(DATA_W-REG_W){1'b0}}, rd_value8};
                end
            end
            BUS_ANSWER: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    always_comb begin
        enables_next = enables_reg;
        if (wr_fire & hit_enables & lane0) begin
            enables_next = wdata8;
        end
    end

    always_comb begin
        core_ctrl_next = core_ctrl_reg;
        if (wr_fire & hit_core & lane0) begin
            core_ctrl_next = wdata8 & CORE_CTRL_MASK;
        end
    end

    always_comb begin
        evt_mask_next = evt_mask_reg;
        if (wr_fire & hit_mask & lane0) begin
            evt_mask_next = wdata8;
        end
    end

    // new rises win over a write-one clear in the same cycle
    assign evt_status_next = (evt_status_reg & ~status_clear) | pend_rise;
    assign irq_next        = |(evt_status_reg & evt_mask_reg);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_state_reg   <= BUS_IDLE;
            waitrequest_reg <= 1'b1;
            readdata_reg    <= '0;
        end else begin
            bus_state_reg   <= bus_state_next;
            waitrequest_reg <= waitrequest_next;
            readdata_reg    <= readdata_next;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            enables_reg   <= ENABLES_RESET;
            core_ctrl_reg <= CORE_CTRL_RESET;
            evt_mask_reg  <= EVT_MASK_RESET;
        end else begin
            enables_reg   <= enables_next;
            core_ctrl_reg <= core_ctrl_next;
            evt_mask_reg  <= evt_mask_next;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            evt_status_reg <= EVT_STATUS_RESET;
            pend_prev_reg  <= '0;
            req_reg        <= 1'b0;
            irq_reg        <= 1'b0;
        end else begin
            evt_status_reg <= evt_status_next;
            pend_prev_reg  <= pend;
            req_reg        <= req_next;
            irq_reg        <= irq_next;
        end
    end

    assign avs_readdata    = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign periph_irq_req  = req_reg;
    assign irq             = irq_reg;
endmodule
